// ---- core/comm_timeout_alarm_ctrl.sv ----
/*
 * Communication timeout watchdog and alarm output control.
 * Assumes: FRAME_VALID_I pulses once per query frame addressed to this
 * station, all inputs are synchronous to CLK_SYS_I, and the framing,
 * load sensing and position sensing are done elsewhere.
 */
// Operation
// [R01] Time since last own-station query; flag timeout when it exceeds setting.
// [R02] Timeout raises network bus error alarm and stops the motor.
// [R03] General setting: -1 uses runtime register, 0 off, else ms; resets -1.
// [R04] Both general setting and register at initial values: no supervision.
// [R05] Runtime register used only when general is -1; 0 off; immediate.
// [R06] During-operation timeout supervises only while operating; same alarm.
// [R07] Any alarm drives alarm-ok and motion outputs off and stops motor.
// [R08] Alarm-clear on with cause gone clears alarm; alarm-ok and ready on.
// [R09] Host drops operation command before clearing an alarm.
// [R10] Host removes the alarm cause before asserting alarm-clear.
// [R11] Host holds alarm-clear until alarm-ok is seen on.
// [R12] Overload threshold 1 to 300 in 0.1 s, default 50.
// [R13] Position deviation threshold 1 to 30000 in 0.01 rev, default 300.
// [R14] Unsupported motor, or small frame on 48 V, raises code 45h.
// [R15] Network bus error reported as code 81h, cleared by normal reset.
// [R16] Excitation alarms keep motor current; non-excitation alarms cut it.
// [R17] Counter steps on 1 ms tick, restarts per frame, compares nonzero setting.
`timescale 1ns/1ns
`default_nettype none

module comm_timeout_alarm_ctrl #(
	parameter int unsigned TICK_CYCLES_P = comm_timeout_alarm_pkg::TICK_CYCLES
) (
	input  wire logic                              CLK_SYS_I,
	input  wire logic                              RSTN_I,
	input  wire logic                              FRAME_VALID_I,
	input  wire logic                              OP_CMD_I,
	input  wire logic                              ALARM_CLEAR_I,
	input  wire logic                              CFG_WR_I,
	input  wire comm_timeout_alarm_pkg::cfg_type   CFG_I,
	input  wire logic                              RT_TIMEOUT_WR_I,
	input  wire logic [15:0]                       RT_TIMEOUT_I,
	input  wire comm_timeout_alarm_pkg::sense_type SENSE_I,
	output logic                                   ALARM_OK_O,
	output logic                                   MOVE_O,
	output logic                                   READY_O,
	output logic                                   MOTOR_STOP_O,
	output logic                                   MOTOR_CURRENT_EN_O,
	output logic                                   TIMEOUT_O,
	output logic [7:0]                             ALARM_CODE_O,
	output logic [15:0]                            RT_TIMEOUT_O,
	output comm_timeout_alarm_pkg::cfg_type        CFG_O
);
	import comm_timeout_alarm_pkg::*;

	// ==========================================================
	// Settings
	cfg_type     cfg;
	logic [15:0] rt_timeout;

	// Out-of-range thresholds are pulled into range rather than rejected
	function automatic cfg_type clamp_cfg(input cfg_type c);
		cfg_type r;
		r = c;
		if (c.overload_limit < OVLD_MIN) begin
			r.overload_limit = OVLD_MIN;
		end else if (c.overload_limit > OVLD_MAX) begin
			r.overload_limit = OVLD_MAX;
		end
		if (c.posdev_limit < POSDEV_MIN) begin
			r.posdev_limit = POSDEV_MIN;
		end else if (c.posdev_limit > POSDEV_MAX) begin
			r.posdev_limit = POSDEV_MAX;
		end
		if (c.gen_timeout < GEN_TIMEOUT_RUNTIME) begin
			r.gen_timeout = GEN_TIMEOUT_RUNTIME;
		end
		return r;
	endfunction

	always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			cfg.gen_timeout    <= GEN_TIMEOUT_RESET; // R03
			cfg.op_timeout     <= OP_TIMEOUT_RESET; // R06
			cfg.overload_limit <= OVLD_RESET; // R12
			cfg.posdev_limit   <= POSDEV_RESET; // R13
		end else if (CFG_WR_I) begin
			cfg <= clamp_cfg(CFG_I); // R12
		end
	end

	always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			rt_timeout <= RT_TIMEOUT_RESET; // R05
		end else if (RT_TIMEOUT_WR_I) begin
			rt_timeout <= RT_TIMEOUT_I;
		end
	end

	// ==========================================================
	// Millisecond tick
	logic [31:0] tick_cnt;
	logic        tick;

	always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			tick_cnt <= 32'h00000000;
			tick     <= 1'b0;
		end else if (tick_cnt >= 32'(TICK_CYCLES_P - 1)) begin
			tick_cnt <= 32'h00000000;
			tick     <= 1'b1; // R17
		end else begin
			tick_cnt <= tick_cnt + 32'h00000001;
			tick     <= 1'b0;
		end
	end

	// ==========================================================
	// Timeout selection
	logic [15:0] gen_limit;
	logic [15:0] op_limit;

	always_comb begin
		if (cfg.gen_timeout == GEN_TIMEOUT_RUNTIME) begin
			gen_limit = rt_timeout; // R05
		end else begin
			gen_limit = cfg.gen_timeout[15:0]; // R03
		end
		op_limit = cfg.op_timeout; // R06
	end

	// ==========================================================
	// Interval counters
	state_type   state;
	logic [16:0] gen_cnt;
	logic [16:0] op_cnt;
	logic        operating;
	logic        restart;

	// Counters also restart at alarm clear so the old gap is not re-judged
	assign restart = FRAME_VALID_I || (state != ST_RUN);
	assign operating = MOVE_O;

	always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			gen_cnt <= 17'h00000;
		end else if (restart) begin
			gen_cnt <= 17'h00000; // R17
		end else if (tick && (gen_cnt != 17'h1FFFF)) begin
			gen_cnt <= gen_cnt + 17'h00001; // R01
		end
	end

	always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			op_cnt <= 17'h00000;
		end else if (restart || !operating) begin
			op_cnt <= 17'h00000; // R06
		end else if (tick && (op_cnt != 17'h1FFFF)) begin
			op_cnt <= op_cnt + 17'h00001;
		end
	end

	logic gen_expired;
	logic op_expired;
	logic comm_timeout;

	// A zero limit means not monitored; with reset settings this is the case
	assign gen_expired  = (gen_limit != 16'h0000) && (gen_cnt > {1'b0, gen_limit}); // R01 R04
	assign op_expired   = (op_limit != 16'h0000) && operating
		&& (op_cnt > {1'b0, op_limit}); // R06
	assign comm_timeout = gen_expired || op_expired;

	// ==========================================================
	// Alarm causes, highest priority first
	logic       combo_cause;
	logic       ovld_cause;
	logic       posdev_cause;
	logic       any_cause;
	logic [7:0] cause_code;
	logic       cause_excite;

	assign combo_cause = SENSE_I.motor_unsupported
		|| (SENSE_I.small_frame && SENSE_I.supply_48v); // R14
	assign ovld_cause   = SENSE_I.overload_time >= cfg.overload_limit; // R12
	assign posdev_cause = SENSE_I.position_dev >= cfg.posdev_limit; // R13
	assign any_cause    = combo_cause || ovld_cause || posdev_cause || comm_timeout;

	always_comb begin
		cause_code   = ALM_NONE;
		cause_excite = 1'b1;
		if (combo_cause) begin
			cause_code   = ALM_COMBO; // R14
			cause_excite = 1'b0;
		end else if (ovld_cause) begin
			cause_code   = ALM_OVERLOAD;
			cause_excite = 1'b0;
		end else if (posdev_cause) begin
			cause_code   = ALM_POSDEV;
			cause_excite = 1'b0;
		end else if (comm_timeout) begin
			cause_code   = ALM_NETBUS; // R02 R15
			cause_excite = 1'b1;
		end
	end

	// ==========================================================
	// Alarm state
	logic clear_d;
	logic clear_rise;
	logic excite;

	always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			clear_d <= 1'b0;
		end else begin
			clear_d <= ALARM_CLEAR_I;
		end
	end

	assign clear_rise = ALARM_CLEAR_I && !clear_d;

	// After a clear, motion waits for the operation command to be seen off,
	// so a command still held by the host cannot restart the motor
	always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			state        <= ST_HOLD_OFF;
			ALARM_CODE_O <= ALM_NONE;
			excite       <= 1'b1;
		end else begin
			case (state)
				ST_RUN: begin
					if (any_cause) begin
						state        <= ST_ALARM; // R02 R07
						ALARM_CODE_O <= cause_code;
						excite       <= cause_excite; // R16
					end
				end
				ST_ALARM: begin
					if (clear_rise && !any_cause) begin
						state        <= ST_HOLD_OFF; // R08 R10
						ALARM_CODE_O <= ALM_NONE;
						excite       <= 1'b1;
					end
				end
				ST_HOLD_OFF: begin
					if (any_cause) begin
						state        <= ST_ALARM;
						ALARM_CODE_O <= cause_code;
						excite       <= cause_excite;
					end else if (!OP_CMD_I) begin
						state <= ST_RUN; // R09
					end
				end
				default: begin
					state <= ST_ALARM;
				end
			endcase
		end
	end

	// ==========================================================
	// Outputs
	logic in_alarm;
	logic next_alarm;

	assign in_alarm   = (state == ST_ALARM);
	assign next_alarm = in_alarm || (state != ST_ALARM && any_cause);

	always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			ALARM_OK_O         <= 1'b0;
			READY_O            <= 1'b0;
			MOVE_O             <= 1'b0;
			MOTOR_STOP_O       <= 1'b1;
			MOTOR_CURRENT_EN_O <= 1'b0;
			TIMEOUT_O          <= 1'b0;
		end else begin
			ALARM_OK_O   <= !next_alarm; // R07 R08
			READY_O      <= !next_alarm; // R08
			MOVE_O       <= !next_alarm && (state == ST_RUN) && OP_CMD_I; // R07
			MOTOR_STOP_O <= next_alarm || (state != ST_RUN) || !OP_CMD_I; // R02 R07
			if (state != ST_ALARM && any_cause) begin
				MOTOR_CURRENT_EN_O <= cause_excite; // R16
			end else begin
				MOTOR_CURRENT_EN_O <= !in_alarm || excite; // R16
			end
			TIMEOUT_O <= comm_timeout; // R01
		end
	end

	always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			RT_TIMEOUT_O <= RT_TIMEOUT_RESET;
			CFG_O        <= '0;
		end else begin
			RT_TIMEOUT_O <= rt_timeout;
			CFG_O        <= cfg;
		end
	end

endmodule

`default_nettype wire

// ---- core/comm_timeout_alarm_pkg.sv ----
/*
 * Constants and carrier types for the communication timeout and alarm
 * controller. Assumes a 250 MHz system clock.
 */
package comm_timeout_alarm_pkg;

	// ==========================================================
	// Timing
	localparam int unsigned CLK_PERIOD_NS  = 4;
	localparam int unsigned TICK_PERIOD_NS = 1000000;
	localparam int unsigned TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;

	// ==========================================================
	// Setting ranges and reset values
	localparam logic signed [16:0] GEN_TIMEOUT_RUNTIME = -17'sd1;
	localparam logic signed [16:0] GEN_TIMEOUT_RESET   = -17'sd1;
	localparam logic [15:0] RT_TIMEOUT_RESET = 16'h0000;
	localparam logic [15:0] OP_TIMEOUT_RESET = 16'h0000;
	localparam logic [8:0]  OVLD_MIN         = 9'h001;
	localparam logic [8:0]  OVLD_MAX         = 9'h12C;
	localparam logic [8:0]  OVLD_RESET       = 9'h032;
	localparam logic [14:0] POSDEV_MIN       = 15'h0001;
	localparam logic [14:0] POSDEV_MAX       = 15'h7530;
	localparam logic [14:0] POSDEV_RESET     = 15'h012C;

	// ==========================================================
	// Alarm codes
	localparam logic [7:0] ALM_NONE     = 8'h00;
	localparam logic [7:0] ALM_COMBO    = 8'h45;
	localparam logic [7:0] ALM_NETBUS   = 8'h81;
	localparam logic [7:0] ALM_OVERLOAD = 8'h01;
	localparam logic [7:0] ALM_POSDEV   = 8'h02;

	// ==========================================================
	// Carriers
	typedef struct packed {
		logic signed [16:0] gen_timeout;
		logic [15:0]        op_timeout;
		logic [8:0]         overload_limit;
		logic [14:0]        posdev_limit;
	} cfg_type;

	typedef struct packed {
		logic [8:0]  overload_time;
		logic [14:0] position_dev;
		logic        motor_unsupported;
		logic        small_frame;
		logic        supply_48v;
	} sense_type;

	typedef enum logic [1:0] {
		ST_RUN,
		ST_ALARM,
		ST_HOLD_OFF
	} state_type;

endpackage

// ---- tb/comm_timeout_alarm_props.sv ----
/* Assertion checker for the timeout alarm controller.
   Sees only the controller ports; bound below the module. */
`timescale 1ns/1ns
`default_nettype none
module comm_timeout_alarm_props
	import comm_timeout_alarm_pkg::*;
#(
	parameter int unsigned TICK_CYCLES_P = 10
) (
	input wire logic                              CLK_SYS_I,
	input wire logic                              RSTN_I,
	input wire logic                              FRAME_VALID_I,
	input wire logic                              ALARM_CLEAR_I,
	input wire logic                              RT_TIMEOUT_WR_I,
	input wire logic [15:0]                       RT_TIMEOUT_I,
	input wire comm_timeout_alarm_pkg::sense_type SENSE_I,
	input wire logic                              ALARM_OK_O,
	input wire logic                              MOVE_O,
	input wire logic                              READY_O,
	input wire logic                              MOTOR_STOP_O,
	input wire logic                              MOTOR_CURRENT_EN_O,
	input wire logic                              TIMEOUT_O,
	input wire logic [7:0]                        ALARM_CODE_O,
	input wire logic [15:0]                       RT_TIMEOUT_O
);
	default clocking @(posedge CLK_SYS_I); endclocking
	default disable iff (!RSTN_I);
	// ==========
	// Alarm outputs
	a_ok_ready: assert property (ALARM_OK_O == READY_O)
		else $error("alarm-ok and ready differ");
	a_stop_alarm: assert property (!ALARM_OK_O |-> !MOVE_O && MOTOR_STOP_O)
		else $error("motion not stopped in alarm");
	a_timeout_code: assert property ($rose(TIMEOUT_O) |-> ALARM_CODE_O == ALM_NETBUS)
		else $error("timeout without code 81");
	a_net_excite: assert property (ALARM_CODE_O == ALM_NETBUS |-> MOTOR_CURRENT_EN_O)
		else $error("current cut on bus error");
	a_combo_raise: assert property (ALARM_OK_O && SENSE_I.small_frame &&
		SENSE_I.supply_48v |-> ##[1:2] ALARM_CODE_O == ALM_COMBO && !MOTOR_CURRENT_EN_O)
		else $error("combination alarm missing");
	// ==========
	// Watchdog and settings
	a_frame_restart: assert property (FRAME_VALID_I |-> ##2 (!$rose(TIMEOUT_O)) [*8])
		else $error("timeout soon after frame");
	a_clear_ack: assert property ($rose(ALARM_CLEAR_I) && ALARM_CODE_O == ALM_NETBUS
		&& !TIMEOUT_O |-> ##2 ALARM_OK_O) else $error("clear not taken");
	a_rt_back: assert property (RT_TIMEOUT_WR_I |-> ##2 RT_TIMEOUT_O == $past(RT_TIMEOUT_I, 2))
		else $error("runtime register readback wrong");
	c_timeout: cover property ($rose(TIMEOUT_O));
	c_combo: cover property (ALARM_CODE_O == ALM_COMBO);
	c_cleared: cover property ($rose(ALARM_OK_O) && ALARM_CLEAR_I);
endmodule
bind comm_timeout_alarm_ctrl comm_timeout_alarm_props #(.TICK_CYCLES_P(TICK_CYCLES_P)) i_props (
	.CLK_SYS_I, .RSTN_I, .FRAME_VALID_I, .ALARM_CLEAR_I, .RT_TIMEOUT_WR_I, .RT_TIMEOUT_I,
	.SENSE_I, .ALARM_OK_O, .MOVE_O, .READY_O, .MOTOR_STOP_O, .MOTOR_CURRENT_EN_O, .TIMEOUT_O,
	.ALARM_CODE_O, .RT_TIMEOUT_O);
`default_nettype wire

// ---- tb/comm_host_model.sv ----
/* Host controller model: periodic query frames, operation command, clear.
   Assumes the bench commands it through level inputs. */
`timescale 1ns/1ns
`default_nettype none
module comm_host_model #(
	parameter int unsigned PERIOD_P = 8
) (
	input  wire logic clk_i,
	input  wire logic rstn_i,
	input  wire logic frames_on_i,
	input  wire logic run_i,
	input  wire logic clear_req_i,
	input  wire logic alarm_ok_i,
	output logic      frame_o,
	output logic      op_cmd_o,
	output logic      alarm_clear_o,
	output logic      clear_done_o
);
	logic [7:0] gap;
	// ==========
	// Frames
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			gap     <= 8'h00;
			frame_o <= 1'b0;
		end else begin
			gap     <= (gap == 8'(PERIOD_P - 1)) ? 8'h00 : gap + 8'h01;
			frame_o <= frames_on_i && gap == 8'h00;
		end
	end
	// ==========
	// Clear handshake; command drops first so the motor cannot lurch
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			op_cmd_o      <= 1'b0;
			alarm_clear_o <= 1'b0;
			clear_done_o  <= 1'b0;
		end else begin
			op_cmd_o <= run_i && !clear_req_i;
			if (clear_req_i && !op_cmd_o && !clear_done_o)
				alarm_clear_o <= 1'b1;
			if (alarm_clear_o && alarm_ok_i) begin
				alarm_clear_o <= 1'b0;
				clear_done_o  <= 1'b1;
			end
			if (!clear_req_i)
				clear_done_o <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// ---- tb/comm_timeout_alarm_ctrl_bench.sv ----
/* Self-checking bench for the timeout alarm controller.
   Host model makes frames and clears; the 1 ms tick is 10 cycles here. */
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin errors++; \
	$display("MISMATCH t=%0t got %h exp %h", $time, (a), (b)); end end
module comm_timeout_alarm_ctrl_bench;
	import comm_timeout_alarm_pkg::*;
	logic        CLK_SYS_I = 1'b0, RSTN_I = 1'b0, CFG_WR_I = 1'b0, RT_TIMEOUT_WR_I = 1'b0;
	logic        frames_on = 1'b0, run = 1'b0, clr_req = 1'b0;
	logic        FRAME_VALID_I, OP_CMD_I, ALARM_CLEAR_I, clr_done, ALARM_OK_O, MOVE_O;
	logic        READY_O, MOTOR_STOP_O, MOTOR_CURRENT_EN_O, TIMEOUT_O;
	logic [15:0] RT_TIMEOUT_I = 16'h0000, RT_TIMEOUT_O;
	logic [7:0]  ALARM_CODE_O;
	cfg_type     CFG_I = '0, CFG_O;
	sense_type   SENSE_I = '0;
	int          errors, total_checks;
	logic [7:0]  exp_code [5] = '{ALM_COMBO, ALM_COMBO, ALM_OVERLOAD, ALM_POSDEV, ALM_NONE};
	comm_timeout_alarm_ctrl #(.TICK_CYCLES_P(10)) i_dut (.CLK_SYS_I, .RSTN_I, .FRAME_VALID_I,
		.OP_CMD_I, .ALARM_CLEAR_I, .CFG_WR_I, .CFG_I, .RT_TIMEOUT_WR_I, .RT_TIMEOUT_I, .SENSE_I,
		.ALARM_OK_O, .MOVE_O, .READY_O, .MOTOR_STOP_O, .MOTOR_CURRENT_EN_O, .TIMEOUT_O,
		.ALARM_CODE_O, .RT_TIMEOUT_O, .CFG_O);
	comm_host_model #(.PERIOD_P(8)) i_host (.clk_i(CLK_SYS_I), .rstn_i(RSTN_I),
		.frames_on_i(frames_on), .run_i(run), .clear_req_i(clr_req), .alarm_ok_i(ALARM_OK_O),
		.frame_o(FRAME_VALID_I), .op_cmd_o(OP_CMD_I), .alarm_clear_o(ALARM_CLEAR_I),
		.clear_done_o(clr_done));
	always #2 CLK_SYS_I = ~CLK_SYS_I;
	// ==========
	// Tasks
	task automatic step(input int n);
		repeat (n) @(posedge CLK_SYS_I);
		#1;
	endtask
	task automatic set_cfg(input logic signed [16:0] g, input logic [15:0] o);
		CFG_I = '{g, o, 9'h000, 15'h7FFF};
		CFG_WR_I = 1'b1;
		step(1);
		CFG_WR_I = 1'b0;
		step(2);
	endtask
	// Drop frames right after one arrives so the silent time is known
	task automatic silence();
		while (FRAME_VALID_I !== 1'b1)
			step(1);
		frames_on = 1'b0;
	endtask
	task automatic expect_timeout(input int n);
		for (int i = 0; i < n && TIMEOUT_O !== 1'b1; i++)
			step(1);
		`CHK(TIMEOUT_O, 1'b1)
	endtask
	task automatic do_clear();
		run = 1'b0;
		clr_req = 1'b1;
		for (int i = 0; i < 50 && clr_done !== 1'b1; i++)
			step(1);
		clr_req = 1'b0;
		step(2);
	endtask
	task automatic summarize();
		if (errors == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		#80000;
		errors++;
		summarize();
	end
	// ==========
	// Tests
	initial begin
		step(8);
		RSTN_I = 1'b1;
		step(2);
		`CHK(ALARM_OK_O, 1'b1)
		`CHK(CFG_O, cfg_type'{GEN_TIMEOUT_RESET, 16'h0000, OVLD_RESET, POSDEV_RESET})
		`CHK(RT_TIMEOUT_O, RT_TIMEOUT_RESET)
		step(100);
		`CHK(TIMEOUT_O, 1'b0)
		run = 1'b1;
		// Frames first: the runtime limit acts at once and would judge the old gap
		frames_on = 1'b1;
		step(10);
		`CHK(MOVE_O, 1'b1)
		RT_TIMEOUT_I = 16'h0003;
		RT_TIMEOUT_WR_I = 1'b1;
		step(1);
		RT_TIMEOUT_WR_I = 1'b0;
		step(200);
		`CHK(TIMEOUT_O, 1'b0)
		`CHK(RT_TIMEOUT_O, 16'h0003)
		silence();
		step(28);
		`CHK(TIMEOUT_O, 1'b0)
		expect_timeout(20);
		`CHK(ALARM_CODE_O, ALM_NETBUS)
		`CHK({ALARM_OK_O, MOVE_O, MOTOR_STOP_O, MOTOR_CURRENT_EN_O}, 4'b0011)
		frames_on = 1'b1;
		do_clear();
		`CHK({ALARM_OK_O, READY_O, ALARM_CODE_O}, {2'b11, ALM_NONE})
		set_cfg(17'sd1, 16'h0000);
		`CHK(CFG_O, cfg_type'{17'sd1, 16'h0000, OVLD_MIN, POSDEV_MAX})
		silence();
		step(9);
		`CHK(TIMEOUT_O, 1'b0)
		expect_timeout(20);
		set_cfg(17'sd0, 16'h0001);
		frames_on = 1'b1;
		do_clear();
		silence();
		step(100);
		`CHK(TIMEOUT_O, 1'b0)
		run = 1'b1;
		expect_timeout(30);
		`CHK(ALARM_CODE_O, ALM_NETBUS)
		set_cfg(17'sd0, 16'h0000);
		do_clear();
		for (int i = 0; i < 5; i++) begin
			case (i)
				0: SENSE_I.motor_unsupported = 1'b1;
				1: SENSE_I = '{9'h000, 15'h0000, 1'b0, 1'b1, 1'b1};
				2: SENSE_I.overload_time = OVLD_MIN;
				3: SENSE_I.position_dev = POSDEV_MAX;
				default: SENSE_I.position_dev = POSDEV_MAX - 15'h0001;
			endcase
			step(3);
			`CHK(ALARM_CODE_O, exp_code[i])
			`CHK(MOTOR_CURRENT_EN_O, exp_code[i] == ALM_NONE)
			SENSE_I = '0;
			do_clear();
			`CHK(ALARM_OK_O, 1'b1)
		end
		set_cfg(-17'sd5, 16'h0000);
		`CHK(CFG_O.gen_timeout, GEN_TIMEOUT_RUNTIME)
		summarize();
	end
endmodule
`default_nettype wire
